/* design/uart_pkg.sv */
/*
  Constants, field positions and carrier types for the host-visible register
  map and queue control of one serial channel.
  Assumes an 8-bit host bus with a 3-bit register offset, one clock (mclk).
*/
// What this block does
// - offset 2 writes go to queue_control, reads return interrupt_ident only.
// - queue_control bit 0 written one enables both transmit and receive FIFOs.
// - other queue_control bits take effect only when bit 0 is set too.
// - any change of the enable bit empties both FIFOs.
// - bit 1 flushes receive FIFO and count, spares shift register, self-clears.
// - bit 2 flushes transmit FIFO and count, spares shift register, self-clears.
// - with FIFOs enabled, bit 3 switches ready pins from mode 0 to mode 1.
// - bits 4 and 5 are reserved and have no effect.
// - bits 6 and 7 hold the receive FIFO trigger level.
// - trigger codes 00,01,10,11 give 1, 4, 8 and 14 bytes.
// - bit 0 is the least significant bit and goes first on the line.
// - without FIFOs, ident bit 3, bits 6-7 and FIFO error bit read zero.
// - line_control bit 7 maps offsets 0 and 1 onto the divisor bytes.
package uart_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets
  localparam logic [2:0] OFS_DATA = 3'h0;
  localparam logic [2:0] OFS_IEN = 3'h1;
  localparam logic [2:0] OFS_IDENT = 3'h2;
  localparam logic [2:0] OFS_LCTRL = 3'h3;
  localparam logic [2:0] OFS_MCTRL = 3'h4;
  localparam logic [2:0] OFS_LSTAT = 3'h5;
  localparam logic [2:0] OFS_MSTAT = 3'h6;
  localparam logic [2:0] OFS_SCRATCH = 3'h7;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int QC_ENABLE = 0;
  localparam int QC_RXFLUSH = 1;
  localparam int QC_TXFLUSH = 2;
  localparam int QC_DMA = 3;
  localparam int QC_TRIG_LO = 6;
  localparam int QC_TRIG_HI = 7;
  localparam int LC_DIVSEL = 7;
  localparam int IE_RXDATA = 0;
  localparam int IE_TXEMPTY = 1;

  ////////////////////////////////////////////////////////////////////////////
  // trigger thresholds in bytes
  localparam logic [4:0] TRIG_CODE0 = 5'h01;
  localparam logic [4:0] TRIG_CODE1 = 5'h04;
  localparam logic [4:0] TRIG_CODE2 = 5'h08;
  localparam logic [4:0] TRIG_CODE3 = 5'h0E;

  ////////////////////////////////////////////////////////////////////////////
  // ident codes, reset values, depths
  localparam logic [3:0] ID_NONE = 4'h1;
  localparam logic [3:0] ID_TXEMPTY = 4'h2;
  localparam logic [3:0] ID_RXDATA = 4'h4;
  localparam logic [7:0] RST_REG = 8'h00;
  localparam int RX_DEPTH = 16;
  localparam int TX_DEPTH = 8;

  typedef struct packed {
    logic [2:0] addr;
    logic [7:0] data;
  } hostReq_s;

endpackage

/* design/uart_register_map_fifo_control.sv */
/*
  Register map and queue control of one serial channel, with a generic
  FIFO module used for both the receive and the transmit queue.
  Assumes host strobes come asynchronously from pins while address and
  write data stay steady around the strobe; byte streams are on mclk.
*/
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////
// generic first-word-fall-through queue
module byte_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic mclk,
  input wire logic srst,
  input wire logic flush,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData,
  output logic [$clog2(DEPTH):0] level
);
  // pointer width; the count carries one bit more to tell full from empty
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [AW:0] count;
  } fifoState_s;

  fifoState_s st_ff;
  fifoState_s nxt_st;
  logic push;
  logic pop;

  // handshakes straight from the count
  // a cast to the pointer width would fold DEPTH to zero, so the full
  // compare is done at the width of the count
  assign inReady = (st_ff.count != (AW+1)'(DEPTH));
  assign outValid = (st_ff.count != '0);
  assign outData = st_ff.mem[st_ff.rdPtr];
  assign level = st_ff.count;
  assign push = inValid & inReady;
  assign pop = outValid & outReady;

  // flush drops everything, even a push in the same cycle
  always_comb begin
    nxt_st = st_ff;
    if (flush) begin
      nxt_st.wrPtr = '0;
      nxt_st.rdPtr = '0;
      nxt_st.count = '0;
    end else begin
      if (push) begin
        nxt_st.mem[st_ff.wrPtr] = inData;
        nxt_st.wrPtr = AW'(st_ff.wrPtr + 1'b1);
      end
      if (pop) begin
        nxt_st.rdPtr = AW'(st_ff.rdPtr + 1'b1);
      end
      if (push && !pop) begin
        nxt_st.count = (AW+1)'(st_ff.count + 1'b1);
      end else if (pop && !push) begin
        nxt_st.count = (AW+1)'(st_ff.count - 1'b1);
      end
    end
  end

  // reset empties the queue; stored bytes are cleared as well
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// register map and queue control
module uart_register_map_fifo_control (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hostWr,
  input wire logic hostRd,
  input wire uart_pkg::hostReq_s hostReq,
  output logic [7:0] hostRdData,
  input wire logic rxValid,
  input wire logic [7:0] rxData,
  output logic rxReady,
  output logic txValid,
  output logic [7:0] txData,
  input wire logic txReady,
  input wire logic txShiftIdle,
  input wire logic [7:0] modemStatusIn,
  output logic receiveReadyPin,
  output logic transmitReadyPin,
  output logic fifosEnabled,
  output logic rxTriggerHit,
  output logic [15:0] baudDivisor,
  output logic [7:0] lineControl,
  output logic [7:0] modemControl,
  output logic [7:0] interruptEnable
);
  // level widths of the two queues
  localparam int RXW = $clog2(uart_pkg::RX_DEPTH);
  localparam int TXW = $clog2(uart_pkg::TX_DEPTH);

  // all register state in one struct, registered by one process
  typedef struct packed {
    logic [2:0] wrSync;
    logic [2:0] rdSync;
    logic wrLvl;
    logic rdLvl;
    logic [7:0] lctrl;
    logic [7:0] ien;
    logic [7:0] mctrl;
    logic [7:0] scratch;
    logic [7:0] divLo;
    logic [7:0] divHi;
    logic fifoEn;
    logic dmaMode;
    logic [1:0] trig;
    logic rxFlush;
    logic txFlush;
    logic [7:0] rdData;
  } regState_s;

  regState_s st_ff;
  regState_s nxt_st;
  logic wrEv;
  logic rdEv;
  logic divSel;
  logic [RXW:0] rxLevel;
  logic [TXW:0] txLevel;
  logic rxOutValid;
  logic [7:0] rxOutData;
  logic rxPop;
  logic rxInReady;
  logic txPush;
  logic txInReady;
  logic [4:0] trigBytes;
  logic rxHasData;
  logic txEmpty;
  logic dmaEff;
  logic [3:0] identCode;
  logic [7:0] identVal;
  logic [7:0] lstatVal;
  logic [7:0] qcWr;

  ////////////////////////////////////////////////////////////////////////////
  // strobe events: third stage must agree with second before a change counts
  assign wrEv = (st_ff.wrSync[1] == st_ff.wrSync[2]) & st_ff.wrSync[2]
                & ~st_ff.wrLvl;
  assign rdEv = (st_ff.rdSync[1] == st_ff.rdSync[2]) & st_ff.rdSync[2]
                & ~st_ff.rdLvl;
  assign divSel = st_ff.lctrl[uart_pkg::LC_DIVSEL];
  assign qcWr = hostReq.data;

  ////////////////////////////////////////////////////////////////////////////
  // trigger threshold lookup
  always_comb begin
    case (st_ff.trig)
      2'b00: trigBytes = uart_pkg::TRIG_CODE0;
      2'b01: trigBytes = uart_pkg::TRIG_CODE1;
      2'b10: trigBytes = uart_pkg::TRIG_CODE2;
      2'b11: trigBytes = uart_pkg::TRIG_CODE3;
      default: trigBytes = uart_pkg::TRIG_CODE0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // queue status and ready pins
  assign rxHasData = (rxLevel != '0);
  assign txEmpty = (txLevel == '0);
  assign rxTriggerHit = st_ff.fifoEn & (5'(rxLevel) >= trigBytes);
  assign dmaEff = st_ff.fifoEn & st_ff.dmaMode;
  // mode 0 follows one byte, mode 1 follows trigger level / free space
  assign receiveReadyPin = dmaEff ? rxTriggerHit : rxHasData;
  assign transmitReadyPin = dmaEff ?
    (txLevel != (TXW+1)'(uart_pkg::TX_DEPTH)) : txEmpty;
  assign fifosEnabled = st_ff.fifoEn;

  // without FIFOs each queue behaves as a single holding byte
  assign rxReady = rxInReady & (st_ff.fifoEn | ~rxHasData);
  assign txPush = wrEv & (hostReq.addr == uart_pkg::OFS_DATA) & ~divSel
                  & (st_ff.fifoEn | txEmpty);
  assign rxPop = rdEv & (hostReq.addr == uart_pkg::OFS_DATA) & ~divSel;

  ////////////////////////////////////////////////////////////////////////////
  // read-only views
  always_comb begin
    if (st_ff.ien[uart_pkg::IE_RXDATA] &&
        (st_ff.fifoEn ? rxTriggerHit : rxHasData)) begin
      identCode = uart_pkg::ID_RXDATA;
    end else if (st_ff.ien[uart_pkg::IE_TXEMPTY] && txEmpty) begin
      identCode = uart_pkg::ID_TXEMPTY;
    end else begin
      identCode = uart_pkg::ID_NONE;
    end
  end

  // no time-out tracking, so ident bit 3 stays zero in every mode
  assign identVal = {st_ff.fifoEn, st_ff.fifoEn, 2'b00,
                     1'b0, identCode[2:0]};
  // fifo error flag is not tracked here and always reads zero
  // bit 6 needs both the queue and the shifter empty
  assign lstatVal = {1'b0, txEmpty & txShiftIdle, txEmpty,
                     4'h0, rxHasData};

  ////////////////////////////////////////////////////////////////////////////
  // register writes, reads and queue control
  always_comb begin
    nxt_st = st_ff;
    // strobe shift chains; only the first stage looks at the pins
    nxt_st.wrSync = {st_ff.wrSync[1:0], hostWr};
    nxt_st.rdSync = {st_ff.rdSync[1:0], hostRd};
    if (st_ff.wrSync[1] == st_ff.wrSync[2]) begin
      nxt_st.wrLvl = st_ff.wrSync[2];
    end
    if (st_ff.rdSync[1] == st_ff.rdSync[2]) begin
      nxt_st.rdLvl = st_ff.rdSync[2];
    end
    // flush requests self-clear after one cycle
    nxt_st.rxFlush = 1'b0;
    nxt_st.txFlush = 1'b0;
    if (wrEv) begin
      case (hostReq.addr)
        // data writes themselves reach the transmit queue via txPush
        uart_pkg::OFS_DATA: begin
          if (divSel) begin
            nxt_st.divLo = hostReq.data;
          end
        end
        // upper enable bits are not built and read back as zero
        uart_pkg::OFS_IEN: begin
          if (divSel) begin
            nxt_st.divHi = hostReq.data;
          end else begin
            nxt_st.ien = {4'h0, hostReq.data[3:0]};
          end
        end
        // queue control; each flush request lasts exactly one cycle
        uart_pkg::OFS_IDENT: begin
          nxt_st.fifoEn = qcWr[uart_pkg::QC_ENABLE];
          if (qcWr[uart_pkg::QC_ENABLE] != st_ff.fifoEn) begin
            nxt_st.rxFlush = 1'b1;
            nxt_st.txFlush = 1'b1;
          end
          // bits 4 and 5 are never looked at
          if (qcWr[uart_pkg::QC_ENABLE]) begin
            nxt_st.dmaMode = qcWr[uart_pkg::QC_DMA];
            nxt_st.trig = qcWr[uart_pkg::QC_TRIG_HI:uart_pkg::QC_TRIG_LO];
            if (qcWr[uart_pkg::QC_RXFLUSH]) begin
              nxt_st.rxFlush = 1'b1;
            end
            if (qcWr[uart_pkg::QC_TXFLUSH]) begin
              nxt_st.txFlush = 1'b1;
            end
          end
        end
        uart_pkg::OFS_LCTRL: nxt_st.lctrl = hostReq.data;
        // modem control keeps only its six defined bits
        uart_pkg::OFS_MCTRL: nxt_st.mctrl = {2'b00, hostReq.data[5:0]};
        uart_pkg::OFS_SCRATCH: nxt_st.scratch = hostReq.data;
        default: nxt_st.scratch = st_ff.scratch;
      endcase
    end
    // read data is latched once per strobe and then held
    if (rdEv) begin
      case (hostReq.addr)
        // a data read also pops the receive queue through rxPop
        uart_pkg::OFS_DATA:
          nxt_st.rdData = divSel ? st_ff.divLo : rxOutData;
        uart_pkg::OFS_IEN:
          nxt_st.rdData = divSel ? st_ff.divHi : st_ff.ien;
        uart_pkg::OFS_IDENT: nxt_st.rdData = identVal;
        uart_pkg::OFS_LCTRL: nxt_st.rdData = st_ff.lctrl;
        uart_pkg::OFS_MCTRL: nxt_st.rdData = st_ff.mctrl;
        uart_pkg::OFS_LSTAT: nxt_st.rdData = lstatVal;
        uart_pkg::OFS_MSTAT: nxt_st.rdData = modemStatusIn;
        uart_pkg::OFS_SCRATCH: nxt_st.rdData = st_ff.scratch;
        default: nxt_st.rdData = 8'h00;
      endcase
    end
  end

  // every field restarts at zero, divisor and scratch included
  always_ff @(posedge mclk) begin
    if (srst) begin
      st_ff <= '0;
      st_ff.lctrl <= uart_pkg::RST_REG;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // queues; bit 0 of each byte is its first bit on the line
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(uart_pkg::RX_DEPTH)
  ) rxQueue (
    .mclk(mclk),
    .srst(srst),
    .flush(st_ff.rxFlush),
    .inValid(rxValid & (st_ff.fifoEn | ~rxHasData)),
    .inReady(rxInReady),
    .inData(rxData),
    .outValid(rxOutValid),
    .outReady(rxPop),
    .outData(rxOutData),
    .level(rxLevel)
  );

  // a full transmit queue refuses host pushes without stalling the bus, the byte is then dropped
  byte_fifo #(
    .WIDTH(8),
    .DEPTH(uart_pkg::TX_DEPTH)
  ) txQueue (
    .mclk(mclk),
    .srst(srst),
    .flush(st_ff.txFlush),
    .inValid(txPush),
    .inReady(txInReady),
    .inData(hostReq.data),
    .outValid(txValid),
    .outReady(txReady),
    .outData(txData),
    .level(txLevel)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register outputs
  assign hostRdData = st_ff.rdData;
  assign baudDivisor = {st_ff.divHi, st_ff.divLo};
  assign lineControl = st_ff.lctrl;
  assign modemControl = st_ff.mctrl;
  assign interruptEnable = st_ff.ien;
endmodule

/* dv/host_model.sv */
/*
  Host processor model driving the parallel register bus.
  Assumes mclk from the bench; strobes move 1 ns after a rising edge.
*/
`timescale 1ns/1ps
module host_model (
  input wire logic mclk,
  output logic hostWr,
  output logic hostRd,
  output uart_pkg::hostReq_s hostReq,
  input wire logic [7:0] hostRdData,
  output logic rdDone,
  output logic [7:0] rdVal
);
  // idle bus at time zero
  initial begin
    hostWr = 1'b0;
    hostRd = 1'b0;
    hostReq = '0;
    rdDone = 1'b0;
    rdVal = 8'h00;
  end
  //////////////////////////////////////////////////////////////////////////
  // one strobe; low time covers the three sync stages
  task automatic cyc(input logic rd, input logic [2:0] a,
                     input logic [7:0] d);
    @(posedge mclk);
    #1;
    hostReq = '{addr: a, data: d};
    if (rd) begin
      hostRd = 1'b1;
    end else begin
      hostWr = 1'b1;
    end
    repeat (6) @(posedge mclk);
    rdVal = hostRdData; // data settled two edges ago
    #1;
    rdDone = rd;
    hostRd = 1'b0;
    hostWr = 1'b0;
    @(posedge mclk);
    #1;
    rdDone = 1'b0;
    repeat (3) @(posedge mclk);
    #1;
    hostReq.data = ~hostReq.data; // released bus must not keep its value
  endtask
endmodule

/* dv/uart_register_map_fifo_control_checker.sv */
/*
  Port checker of the register map and queue control.
  Assumes one clock mclk and synchronous reset srst.
*/
`timescale 1ns/1ps
module uart_register_map_fifo_control_checker (
  input wire logic mclk,
  input wire logic srst,
  input wire logic hostWr,
  input wire logic rxReady,
  input wire logic txValid,
  input wire logic receiveReadyPin,
  input wire logic transmitReadyPin,
  input wire logic fifosEnabled,
  input wire logic rxTriggerHit,
  input wire logic [15:0] baudDivisor
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  //////////////////////////////////////////////////////////////////////////
  // relations between outputs; mode checks need the enable state
  reset_vals_a: assert property ($fell(srst) |-> !fifosEnabled &&
    baudDivisor == 16'h0000 && transmitReadyPin && !receiveReadyPin)
    else $error("bad state after reset");
  write_gate_a: assert property ((!hostWr) [*5] |-> $stable(baudDivisor)
    && $stable(fifosEnabled)) else $error("register moved without write");
  en_flush_a: assert property ($changed(fifosEnabled) |=> !txValid)
    else $error("enable change kept tx bytes");
  trig_off_a: assert property (!fifosEnabled |-> !rxTriggerHit)
    else $error("trigger hit without fifos");
  trig_ready_a: assert property (rxTriggerHit |-> receiveReadyPin)
    else $error("rx ready low at trigger");
  tx_mode0_a: assert property (!fifosEnabled |->
    transmitReadyPin == !txValid) else $error("tx ready wrong in mode 0");
  rx_mode0_a: assert property (!fifosEnabled |->
    receiveReadyPin == !rxReady) else $error("rx ready wrong in mode 0");
  tx_empty_a: assert property (!txValid |-> transmitReadyPin)
    else $error("tx ready low while empty");
endmodule

bind uart_register_map_fifo_control uart_register_map_fifo_control_checker
  chk_i (.mclk(mclk), .srst(srst), .hostWr(hostWr), .rxReady(rxReady),
  .txValid(txValid), .receiveReadyPin(receiveReadyPin),
  .transmitReadyPin(transmitReadyPin), .fifosEnabled(fifosEnabled),
  .rxTriggerHit(rxTriggerHit), .baudDivisor(baudDivisor));

/* dv/testbench.sv */
/*
  Self-checking bench of the register map and queue control.
  Assumes host_model as the bus partner; byte streams driven here.
*/
`timescale 1ns/1ps
module testbench;
  logic mclk, srst, rxValid, txReady, hostWr, hostRd, rdDone;
  logic rxReady, txValid, rrPin, trPin, fen, trig;
  logic [7:0] rxData, hostRdData, rdVal, txData;
  logic [15:0] baudDivisor;
  logic [7:0] lc, mc, ie;
  logic [7:0] rxQ[$];
  logic [7:0] rdQ[$];
  logic [7:0] txQ[$];
  uart_pkg::hostReq_s hostReq;
  int err_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  int transmit_holding[4] = '{1, 4, 8, 14};
  logic [7:0] b;
  // free-running clock
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  uart_register_map_fifo_control DUT (.mclk(mclk), .srst(srst),
    .hostWr(hostWr), .hostRd(hostRd), .hostReq(hostReq),
    .hostRdData(hostRdData), .rxValid(rxValid), .rxData(rxData),
    .rxReady(rxReady), .txValid(txValid), .txData(txData),
    .txReady(txReady), .txShiftIdle(1'b1), .modemStatusIn(8'h5A),
    .receiveReadyPin(rrPin), .transmitReadyPin(trPin),
    .fifosEnabled(fen), .rxTriggerHit(trig), .baudDivisor(baudDivisor),
    .lineControl(lc), .modemControl(mc), .interruptEnable(ie));
  host_model HOST (.mclk(mclk), .hostWr(hostWr), .hostRd(hostRd),
    .hostReq(hostReq), .hostRdData(hostRdData), .rdDone(rdDone),
    .rdVal(rdVal));
  //////////////////////////////////////////////////////////////////////////
  // shared comparison, verdict and bus tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compared %0d, mismatched %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    HOST.cyc(1'b0, a, d);
  endtask
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    rdQ.push_back(e);
    HOST.cyc(1'b1, a, 8'h00);
  endtask
  // offer n receive bytes, each held until taken
  task automatic push(input int n);
    repeat (n) begin
      @(posedge mclk);
      #1;
      rxValid = 1'b1;
      rxData = 8'($urandom);
      do @(posedge mclk); while (rxReady !== 1'b1);
      #1;
      rxQ.push_back(rxData); // byte taken at that edge
      rxValid = 1'b0;
      rxData = ~rxData; // idle data never repeats the last byte
    end
    @(posedge mclk);
    #1;
  endtask
  //////////////////////////////////////////////////////////////////////////
  // result watcher with hang guard; queues hold the expectations
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 20000) begin
      err_count++;
      give_verdict();
    end
    if (rdDone === 1'b1 && rdQ.size() > 0) begin
      chk(16'(rdVal), 16'(rdQ.pop_front()));
    end
    if (txValid === 1'b1 && txReady === 1'b1 && txQ.size() > 0) begin
      chk(16'(txData), 16'(txQ.pop_front()));
    end
  end
  //////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    srst = 1'b1;
    rxValid = 1'b0;
    txReady = 1'b0;
    rxData = 8'h00;
    void'($urandom(32'h113b8b7d));
    repeat (5) @(posedge mclk);
    #1;
    srst = 1'b0;
    rd(3'h2, 8'h01);
    rd(3'h5, 8'h60);
    wr(3'h7, 8'hA5);
    rd(3'h7, 8'hA5);
    wr(3'h2, 8'hCE);
    chk(16'(fen), 16'h0000);
    $display("legacy mode test done");
    wr(3'h3, 8'h80);
    wr(3'h0, 8'h34);
    wr(3'h1, 8'h12);
    chk(baudDivisor, 16'h1234);
    chk(16'(lc), 16'h0080);
    rd(3'h2, 8'h01);
    rd(3'h0, 8'h34);
    wr(3'h3, 8'h00);
    $display("divisor test done");
    for (int c = 0; c < 4; c++) begin
      wr(3'h2, {2'(c), 2'($urandom), 4'hB});
      push(transmit_holding[c] - 1);
      chk(16'({trig, rrPin}), 16'h0000);
      push(1);
      chk(16'({trig, rrPin}), 16'h0003);
    end
    rd(3'h2, 8'hC1);
    wr(3'h2, 8'h00);
    chk(16'({fen, rrPin}), 16'h0000);
    $display("trigger test done");
    wr(3'h2, 8'h09);
    repeat (9) wr(3'h0, 8'($urandom));
    chk(16'({txValid, trPin}), 16'h0002);
    wr(3'h2, 8'h05);
    chk(16'({txValid, trPin}), 16'h0001);
    repeat (2) begin
      b = 8'($urandom);
      txQ.push_back(b);
      wr(3'h0, b);
    end
    txReady = 1'b1;
    repeat (3) @(posedge mclk);
    #1;
    txReady = 1'b0;
    chk(16'(txQ.size()), 16'h0000);
    $display("transmit test done");
    wr(3'h2, 8'h03);
    rxQ.delete();
    wr(3'h1, 8'hFF);
    wr(3'h4, 8'hFF);
    chk(16'({ie, mc}), 16'h0F3F);
    rd(3'h1, 8'h0F);
    rd(3'h4, 8'h3F);
    rd(3'h6, 8'h5A);
    rd(3'h2, 8'hC2);
    push(2);
    rd(3'h2, 8'hC4);
    repeat (2) rd(3'h0, rxQ.pop_front());
    wr(3'h2, 8'h00);
    rxQ.delete();
    push(1);
    chk(16'({rxReady, rrPin}), 16'h0001);
    rd(3'h2, 8'h04);
    rd(3'h0, rxQ.pop_front());
    $display("register test done");
    give_verdict();
  end
endmodule
